// ---- verification/ext_irq_board.sv ----
// Board model for the six interrupt pins and the low-frequency clock.
// Assumes the bench sets the wanted pin levels; the wires follow after a board delay.
`timescale 1ns/1ps

module ext_irq_board (
    input wire logic [5:0] level_i,
    output wire logic [5:0] pin_o,
    output logic low_clk_o
);
    // ----------------------------------------
    // Low clock
    // ----------------------------------------
    // Free running oscillator, 70 ns period, phase unrelated to the gear clock
    initial begin
        low_clk_o = 1'b0;
        #13;
        forever #35 low_clk_o = ~low_clk_o;
    end

    // Pins follow the wanted level, asynchronous to the gear clock
    assign #3 pin_o = level_i;
endmodule

// ---- verification/external_irq_filter_detect_tb_top.sv ----
// Self-checking bench for the external interrupt filter block.
// Assumes the board model drives the pins and the low clock; APB master lives here.
`timescale 1ns/1ps

module external_interrupt_filter_detect_tb_top;
    import ext_irq_pkg::*;

    logic clk_i;
    logic rst_n_i;
    logic low_clk;
    apb_req_type apb;
    apb_rsp_type rsp;
    mode_type mode;
    logic [5:0] lvl;
    logic [5:0] pins;
    logic [5:0] req;
    logic [31:0] rd;
    logic err;
    int failures;
    int tests_run;
    int cnt[6];
    int base[6];
    int p;

    ext_irq_board board (.level_i(lvl), .pin_o(pins), .low_clk_o(low_clk));
    ext_irq_filter DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .apb_i(apb), .apb_o(rsp), .op_mode_i(mode),
        .low_freq_clock_i(low_clk), .ext_irq_pin_i(pins), .irq_req_o(req));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Request pulse counters
    always @(posedge clk_i) begin
        for (int i = 0; i < 6; i++) cnt[i] <= cnt[i] + int'(req[i]);
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic close_out();
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_reqs(input int s, input int e);
        tests_run++;
        if (cnt[s] - base[s] != e) begin
            failures++;
            $display("mismatch at %0t: source %0d gave %0d requests, expected %0d", $time, s, cnt[s] - base[s], e);
        end
    endtask

    // One APB transfer, held until pready is seen
    task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge clk_i);
        apb.penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        rd = rsp.prdata;
        err = rsp.pslverr;
        apb <= '0;
        if (n >= 20) begin
            failures++;
            close_out();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb_xfer(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb_xfer(1'b0, a, 32'h0);
        check(rd, e);
    endtask

    // Low pulse of len cycles on source s, then settle
    task automatic pulse(input int s, input int len, input int e);
        base = cnt;
        lvl[s] <= 1'b0;
        repeat (len) @(posedge clk_i);
        lvl[s] <= 1'b1;
        repeat (100) @(posedge clk_i);
        check_reqs(s, e);
    endtask

    function automatic int edges(input logic [1:0] c);
        return (c == COND_BOTH) ? 2 : (c == COND_HIGH) ? 0 : 1;
    endfunction

    function automatic int per(input logic [1:0] nc);
        return (nc == 2'h0) ? 1 : (1 << (nc + 1));
    endfunction

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_n_i = 1'b0;
        apb = '0;
        mode = MODE_HS;
        lvl = 6'h3f;
        failures = 0;
        tests_run = 0;
        void'($urandom(32'hc2cc68ca));
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rdchk(OFS_POWER_GATE, 32'h0);
        rdchk(OFS_IRQ_ENABLE, 32'h0);
        rdchk(12'h01c, 32'h0);
        check({31'h0, err}, 32'h1);
        wr(OFS_POWER_GATE, 32'h3f);
        for (int s = 1; s < 5; s++) begin
            apb_xfer(1'b1, 12'(4 * s), 32'hffffffff);
            apb_xfer(1'b0, 12'(4 * s), 32'h0);
            check(rd & 32'hffffffef, 32'h0000000f);
            wr(12'(4 * s), 32'h0);
        end
        repeat (40) @(posedge clk_i);
        rdchk(OFS_LEVEL, 32'h3f);
        wr(OFS_IRQ_ENABLE, 32'h7f);
        pulse(0, 2 + $urandom % 4, 1);
        pulse(5, 2 + $urandom % 4, 1);
        // Every condition code, spread over configurable sources 1 to 3
        for (int c = 0; c < 4; c++) begin
            wr(12'(4 * (1 + c % 3)), {28'h0, 2'(c), 2'($urandom % 4)});
            pulse(1 + c % 3, 60, edges(2'(c)));
            apb_xfer(1'b0, 12'(4 * (1 + c % 3)), 32'h0);
            if (c != 3) check({31'h0, rd[4]}, {31'h0, c != 1});
        end
        // Noise limits for each sampling interval
        for (int nc = 0; nc < 4; nc++) begin
            wr(12'h010, {28'h0, COND_BOTH, 2'(nc)});
            p = per(2'(nc));
            pulse(4, 1 + $urandom % (2 * p - 1), 0);
            pulse(4, 3 * p + 4 + $urandom % 4, 2);
        end
        wr(12'h010, {28'h0, COND_HIGH, 2'h0});
        base = cnt;
        repeat (20) @(posedge clk_i);
        check({31'h0, cnt[4] - base[4] >= 10}, 32'h1);
        wr(OFS_IRQ_ENABLE, 32'h6f);
        repeat (4) @(posedge clk_i);
        pulse(4, 1, 0);
        wr(OFS_IRQ_ENABLE, 32'h3f);
        repeat (4) @(posedge clk_i);
        pulse(4, 1, 0);
        wr(12'h010, 32'h0);
        wr(OFS_POWER_GATE, 32'h3e);
        wr(OFS_IRQ_ENABLE, 32'h7f);
        pulse(0, 10, 0);
        wr(OFS_IRQ_ENABLE, 32'h0);
        wr(OFS_POWER_GATE, 32'h3f);
        wr(OFS_IRQ_ENABLE, 32'h7f);
        pulse(0, 10, 1);
        wr(OFS_IRQ_ENABLE, 32'h0);
        // Both edges on every configurable source for the slow run
        for (int s = 1; s < 5; s++) begin
            wr(12'(4 * s), {28'h0, COND_BOTH, 2'($urandom % 4)});
        end
        mode <= MODE_LS;
        repeat (100) @(posedge clk_i);
        wr(OFS_IRQ_ENABLE, 32'h7f);
        for (int s = 0; s < 6; s++) begin
            pulse(s, 1 + $urandom % 26, 0);
            pulse(s, 60 + $urandom % 8, (s % 5 == 0) ? 1 : 2);
        end
        mode <= MODE_DEEP;
        pulse(0, 80, 0);
        wr(OFS_IRQ_ENABLE, 32'h0);
        mode <= MODE_HS;
        repeat (60) @(posedge clk_i);
        wr(OFS_IRQ_ENABLE, 32'h7f);
        pulse(0, 10, 1);
        wr(OFS_IRQ_ENABLE, 32'h0);
        pulse(0, 10, 0);
        close_out();
    end
endmodule

// ---- verilog/ext_irq_filter.sv ----
// Noise filters and request detection for six external interrupt pins.
// Assumes clk_i is the gear clock, pins and the low clock are asynchronous.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

module ext_irq_filter (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire ext_irq_pkg::apb_req_type apb_i,
    output ext_irq_pkg::apb_rsp_type apb_o,
    input wire ext_irq_pkg::mode_type op_mode_i,
    input wire logic low_freq_clock_i,
    input wire logic [5:0] ext_irq_pin_i,
    output logic [5:0] irq_req_o
);
    import ext_irq_pkg::*;

    // ----------------------------------------
    // Registers and state
    // ----------------------------------------
    logic [5:0] irq_clock_gate_enable;
    logic [5:0] irq_enable;
    logic master_irq_enable;
    logic [3:0] ext_irq_control_reg [NSRC];
    logic filtered_level_flag [NSRC];
    logic filt [NSRC];
    logic clean [NSRC];
    logic [1:0] hist [NSRC];
    logic [5:0] hit;
    logic [3:0] div_cnt;
    logic [2:0] lf_sync;
    logic lf_clean;
    logic lf_prev;
    logic [1:0] fs_cnt;

    // ----------------------------------------
    // Mode and tick decode
    // ----------------------------------------
    wire is_hs = (op_mode_i == MODE_HS);
    wire is_ls = (op_mode_i == MODE_LS);
    wire fs_edge = lf_clean & ~lf_prev;
    wire tick_fs4 = fs_edge & (fs_cnt == FS_DIV_LAST);
    wire [3:0] nc_tick;

    // Gear clock divided by 1, 4, 8, 16
    // interval divisor taps
    assign nc_tick[0] = 1'b1;
    assign nc_tick[1] = (div_cnt[1:0] == 2'h3);
    assign nc_tick[2] = (div_cnt[2:0] == 3'h7);
    assign nc_tick[3] = (div_cnt == 4'hf);

    // Free divider for sampling intervals
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    // Low clock synchroniser, two-of-three agree
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lf_sync <= 3'h0;
            lf_clean <= 1'b0;
            lf_prev <= 1'b0;
        end else begin
            lf_sync <= {lf_sync[1:0], low_freq_clock_i};
            if (lf_sync[1] == lf_sync[2]) begin
                lf_clean <= lf_sync[2];
            end
            lf_prev <= lf_clean;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fs_cnt <= 2'h0;
        end else if (fs_edge) begin
            fs_cnt <= fs_cnt + 2'h1;
        end
    end

    // ----------------------------------------
    // Per-source filter and detector
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < NSRC; i++) begin : g_src
            logic [2:0] sync;
            wire fixed = (i == 0) || (i == NSRC - 1);
            wire [1:0] nc = ext_irq_control_reg[i][CTRL_NC_LSB +: 2];
            wire [1:0] es = ext_irq_control_reg[i][CTRL_ES_LSB +: 2];
            wire run = irq_clock_gate_enable[i] & (is_hs | is_ls);
            wire tick = run & (is_ls ? tick_fs4 : (fixed ? 1'b1 : nc_tick[nc]));
            wire agree = is_ls ? (clean[i] == hist[i][0]) :
                fixed ? 1'b1 : ((clean[i] == hist[i][0]) && (clean[i] == hist[i][1]));
            wire edge_seen = tick & agree & (clean[i] != filt[i]);
            wire new_lvl = edge_seen ? clean[i] : filt[i];
            wire rise = edge_seen & clean[i];
            wire fall = edge_seen & ~clean[i];
            logic det;

            // Condition select
            // rise, fall, both decode
            // fixed falling edge on 0 and 5
            always_comb begin
                det = 1'b0;
                if (fixed) begin
                    det = fall;
                end else begin
                    unique case (es)
                        COND_RISE: det = rise;
                        COND_FALL: det = fall;
                        COND_BOTH: det = edge_seen;
                        COND_HIGH: det = (i == 4) ? (tick & new_lvl) : 1'b0;
                    endcase
                end
            end
            assign hit[i] = det;

            // Pin synchroniser, two-of-three agree
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    sync <= 3'h0;
                    clean[i] <= 1'b0;
                end else begin
                    sync <= {sync[1:0], ext_irq_pin_i[i]};
                    if (sync[1] == sync[2]) begin
                        clean[i] <= sync[2];
                    end
                end
            end

            // Sample history and filtered level
            // short inputs never pass
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    hist[i] <= 2'h0;
                    filt[i] <= 1'b0;
                end else if (tick) begin
                    hist[i] <= {hist[i][0], clean[i]};
                    filt[i] <= new_lvl;
                end
            end

            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    filtered_level_flag[i] <= 1'b0;
                end else if (det) begin
                    filtered_level_flag[i] <= new_lvl;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_req_o <= 6'h00;
        end else begin
            irq_req_o <= hit & irq_enable & {6{master_irq_enable}};
        end
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    wire access = apb_i.psel & apb_i.penable;
    wire done = access & apb_o.pready;
    wire wr = done & apb_i.pwrite;
    wire [9:0] word = apb_i.paddr[11:2];
    wire hit_gate = (apb_i.paddr == OFS_POWER_GATE);
    wire hit_en = (apb_i.paddr == OFS_IRQ_ENABLE);
    wire hit_lvl = (apb_i.paddr == OFS_LEVEL);
    wire hit_ctrl = (apb_i.paddr[1:0] == 2'h0) && (word >= 10'h1) && (word <= 10'h4);
    wire [2:0] csel = word[2:0];
    wire mapped = hit_gate | hit_en | hit_lvl | hit_ctrl;
    wire [5:0] lvl_vec;
    logic [31:0] rd_data;

    for (i = 0; i < NSRC; i++) begin : g_lvl
        assign lvl_vec[i] = filt[i];
    end

    // Read mux
    // upper control bits read zero
    always_comb begin
        rd_data = 32'h0;
        if (hit_gate) begin
            rd_data[5:0] = irq_clock_gate_enable;
        end else if (hit_en) begin
            rd_data[6:0] = {master_irq_enable, irq_enable};
        end else if (hit_lvl) begin
            rd_data[5:0] = lvl_vec;
        end else if (hit_ctrl) begin
            rd_data[3:0] = ext_irq_control_reg[csel];
            rd_data[CTRL_LVL_BIT] = filtered_level_flag[csel];
        end
    end

    // Response: one wait state, error on unmapped
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            apb_o <= '0;
        end else begin
            apb_o.pready <= access & ~apb_o.pready;
            apb_o.pslverr <= access & ~apb_o.pready & ~mapped;
            apb_o.prdata <= (access & ~apb_o.pready) ? rd_data : 32'h0;
        end
    end

    // Register writes
    // gate enables clear on reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_clock_gate_enable <= GATE_RST;
            {master_irq_enable, irq_enable} <= EN_RST;
            for (int k = 0; k < NSRC; k++) begin
                ext_irq_control_reg[k] <= CTRL_RST;
            end
        end else if (wr) begin
            if (hit_gate) begin
                irq_clock_gate_enable <= apb_i.pwdata[5:0];
            end
            if (hit_en) begin
                {master_irq_enable, irq_enable} <= apb_i.pwdata[6:0];
            end
            if (hit_ctrl) begin
                ext_irq_control_reg[csel] <= apb_i.pwdata[3:0];
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_gate_off;
        (~$past(irq_clock_gate_enable) & irq_req_o) == 6'h00;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("request from gated source");

    property p_reset_gate;
        @(posedge clk_i) disable iff (1'b0) !rst_n_i |=> irq_clock_gate_enable == 6'h00;
    endproperty
    a_reset_gate: assert property (p_reset_gate) else $error("gate not cleared by reset");

    property p_deep;
        !(is_hs | is_ls) |=> irq_req_o == 6'h00;
    endproperty
    a_deep: assert property (p_deep) else $error("request in deep mode");

    property p_src4_en;
        irq_req_o[4] |-> $past(master_irq_enable & irq_enable[4]);
    endproperty
    a_src4_en: assert property (p_src4_en) else $error("source 4 request while disabled");

    property p_src0_fast;
        $past(is_hs & irq_clock_gate_enable[0]) && $changed(filt[0]) |-> filt[0] == $past(clean[0]);
    endproperty
    a_src0_fast: assert property (p_src0_fast) else $error("source 0 fast filter");

    property p_src0_slow;
        $past(is_ls) && $changed(filt[0]) |-> $past(tick_fs4 && clean[0] == hist[0][0]);
    endproperty
    a_src0_slow: assert property (p_src0_slow) else $error("source 0 slow filter");

    property p_three;
        $past(is_hs) && $changed(filt[2]) |-> $past(hist[2][0] == clean[2] && hist[2][1] == clean[2]);
    endproperty
    a_three: assert property (p_three) else $error("level taken without three samples");

    property p_slow_tick;
        $past(is_ls) && $changed(filt[3]) |-> $past(tick_fs4);
    endproperty
    a_slow_tick: assert property (p_slow_tick) else $error("slow sample off fs/4");

    property p_div4;
        $past(is_hs && ext_irq_control_reg[1][1:0] == 2'h1) && $changed(filt[1])
            |-> $past(div_cnt[1:0]) == 2'h3;
    endproperty
    a_div4: assert property (p_div4) else $error("interval 01 not divide by 4");

    property p_rise;
        irq_req_o[1] && $past(ext_irq_control_reg[1][3:2] == COND_RISE) |-> filt[1] && !$past(filt[1]);
    endproperty
    a_rise: assert property (p_rise) else $error("rise request without rising edge");

    property p_high;
        irq_req_o[4] && $past(ext_irq_control_reg[4][3:2] == COND_HIGH) |-> filt[4];
    endproperty
    a_high: assert property (p_high) else $error("high level request while low");

    property p_level;
        irq_req_o[2] |-> filtered_level_flag[2] == filt[2];
    endproperty
    a_level: assert property (p_level) else $error("level flag not refreshed");

    property p_upper;
        apb_o.pready && $past(hit_ctrl) |-> apb_o.prdata[31:5] == 27'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("control upper bits not zero");

    property p_src5;
        irq_req_o[5] |-> !filt[5] && $past(filt[5]) ##1 !irq_req_o[5];
    endproperty
    a_src5: assert property (p_src5) else $error("source 5 not single falling pulse");

    property p_pulse;
        irq_req_o[0] |=> !irq_req_o[0];
    endproperty
    a_pulse: assert property (p_pulse) else $error("request longer than one cycle");

    c_src0: cover property (irq_req_o[0]);
    c_both: cover property (irq_req_o[3] && $past(ext_irq_control_reg[3][3:2] == COND_BOTH));
    c_slow: cover property (is_ls && irq_req_o[1]);
    c_err: cover property (apb_o.pslverr);

endmodule

// ---- verilog/ext_irq_pkg.sv ----
// Constants and types for the external interrupt filter block.
// Assumes an APB master on clk_i and a one-hot mode code from the clock controller.
package ext_irq_pkg;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int NSRC = 6;
    localparam int AW = 12;

    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [11:0] OFS_POWER_GATE = 12'h000;
    localparam logic [11:0] OFS_CTRL_BASE = 12'h000; // Source x at 4*x, x = 1..4
    localparam logic [11:0] OFS_IRQ_ENABLE = 12'h014;
    localparam logic [11:0] OFS_LEVEL = 12'h018;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL_NC_LSB = 0;
    localparam int CTRL_ES_LSB = 2;
    localparam int CTRL_LVL_BIT = 4;
    localparam int EN_MASTER_BIT = 6;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [5:0] GATE_RST = 6'h00;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [6:0] EN_RST = 7'h00;

    // ----------------------------------------
    // Detection condition codes
    // ----------------------------------------
    localparam logic [1:0] COND_RISE = 2'h0;
    localparam logic [1:0] COND_FALL = 2'h1;
    localparam logic [1:0] COND_BOTH = 2'h2;
    localparam logic [1:0] COND_HIGH = 2'h3;

    // ----------------------------------------
    // Timing counts
    // ----------------------------------------
    localparam int CLK_MHZ = 100;
    localparam logic [1:0] FS_DIV_LAST = 2'h3; // Low clock divided by 4

    // Operating mode, one-hot
    typedef enum logic [2:0] {
        MODE_HS = 3'b001,
        MODE_LS = 3'b010,
        MODE_DEEP = 3'b100
    } mode_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_type;

endpackage
